// ==== hdl/uefd_pkg.sv ====
// package of constants and types for the usb endpoint fifo and dma request block
package uefd_pkg;
    // fifo ram
    localparam int unsigned FIFO_BYTES    = 4096;
    localparam int unsigned EP0_BYTES     = 64;
    localparam int unsigned FREE_BYTES    = FIFO_BYTES - EP0_BYTES;
    localparam int unsigned NUM_EP        = 3;
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned CNT_W         = 13;
    localparam int unsigned CLK_MHZ       = 125;

    // register offsets (byte addresses; the SUB_ codes are word indices inside an endpoint block)
    localparam logic [11:0] OFF_CTRL      = 12'h000;
    localparam logic [11:0] OFF_STATUS    = 12'h004;
    localparam logic [11:0] OFF_IRQ       = 12'h008;
    localparam logic [11:0] OFF_ID        = 12'h00c;
    localparam logic [11:0] OFF_EP_BASE   = 12'h040;
    localparam logic [11:0] OFF_EP_STRIDE = 12'h020;
    localparam logic [2:0]  SUB_TX_CFG    = 3'h0;
    localparam logic [2:0]  SUB_TX_FIFO   = 3'h1;
    localparam logic [2:0]  SUB_RX_CFG    = 3'h2;
    localparam logic [2:0]  SUB_RX_FIFO   = 3'h3;
    localparam logic [2:0]  SUB_TX_CNT    = 3'h4;
    localparam logic [2:0]  SUB_RX_CNT    = 3'h5;
    localparam logic [2:0]  SUB_DMA_LEN   = 3'h6;

    // config field positions
    localparam int unsigned CFG_DMA_EN    = 0;
    localparam int unsigned CFG_MODE      = 1;
    localparam int unsigned CFG_AUTO      = 2;
    localparam int unsigned CFG_PKT_LSB   = 4;
    localparam int unsigned CFG_PKT_W     = 11;
    localparam int unsigned FIFO_SIZE_LSB = 16;
    localparam int unsigned CTRL_HOST     = 0;
    localparam logic [31:0] RST_VAL       = 32'h0000_0000;
    localparam logic [31:0] ID_VALUE      = 32'h0000_5a01; // arbitrary value

    typedef enum logic [0:0] {
        UEFD_MODE_PER_PACKET = 1'b0,
        UEFD_MODE_BLOCK      = 1'b1
    } uefd_mode_t;

    typedef struct packed {
        logic       dma_en;
        uefd_mode_t mode;
        logic       auto_op;
        logic [10:0] max_pkt;
    } uefd_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] start;
        logic [CNT_W-1:0]  size;
    } uefd_fifo_t;

    // link-side received packet event per endpoint
    typedef struct packed {
        logic       valid;
        logic [10:0] bytes;
    } uefd_pkt_t;
endpackage : uefd_pkg

// ==== hdl/uefd_top.sv ====
// usb endpoint fifo space accounting and dma request logic with apb registers
`timescale 1ns/1ps
`default_nettype none
module uefd_top #(
    parameter int unsigned N_EP = uefd_pkg::NUM_EP
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // link side, per endpoint 1..3 (index 0 = endpoint 1)
    input  wire logic [N_EP-1:0]          link_tx_taken,
    input  wire logic [N_EP-1:0]          link_tx_done,
    input  wire logic [N_EP-1:0]          link_err,
    input  wire uefd_pkg::uefd_pkt_t      link_rx_pkt [N_EP],
    output logic      [N_EP-1:0]          link_tx_armed,
    // dma side, channel strobes move one byte each
    input  wire logic [N_EP-1:0]          dma_tx_write,
    input  wire logic [N_EP-1:0]          dma_rx_read,
    output logic      [N_EP-1:0]          dma_rx_req,
    output logic      [N_EP-1:0]          dma_tx_req,
    // shared interrupt
    output logic                          irq
);
    localparam int unsigned CW = uefd_pkg::CNT_W;

    uefd_pkg::uefd_cfg_t  tx_cfg_q   [N_EP];
    uefd_pkg::uefd_cfg_t  rx_cfg_q   [N_EP];
    uefd_pkg::uefd_fifo_t tx_fifo_q  [N_EP];
    uefd_pkg::uefd_fifo_t rx_fifo_q  [N_EP];
    logic [CW-1:0]        tx_cnt_q   [N_EP];
    logic [CW-1:0]        rx_cnt_q   [N_EP];
    logic [CW-1:0]        rx_pkt_q   [N_EP];
    logic [15:0]          tx_len_q   [N_EP];
    logic [15:0]          rx_len_q   [N_EP];
    logic [N_EP-1:0]      armed_q;
    logic                 host_q;
    logic [31:0]          irq_q;
    logic [31:0]          irq_set;
    logic                 wr_acc;
    logic                 hit;
    logic [31:0]          rd_d;
    logic [31:0]          irq_clr;

    // true when address falls in endpoint block n, sub register s
    function automatic logic ep_hit(input logic [11:0] a, input int unsigned n, input logic [2:0] s);
        logic [11:0] b;
        b = uefd_pkg::OFF_EP_BASE + 12'(n) * uefd_pkg::OFF_EP_STRIDE + {7'h00, s, 2'b00};
        return a == b;
    endfunction

    // fifo window legal: outside endpoint zero area and inside the ram
    function automatic logic fifo_ok(input logic [31:0] w);
        logic [31:0] e;
        e = {20'h00000, w[11:0]} + {19'h00000, w[28:16]};
        return (w[11:0] >= 12'(uefd_pkg::EP0_BYTES)) &&
               (e <= 32'(uefd_pkg::FIFO_BYTES));
    endfunction

    assign pready  = 1'b1;
    assign wr_acc  = psel & penable & pwrite;
    assign pslverr = psel & penable & ~hit;
    assign irq     = |irq_q;

    // register decode and read mux
    always_comb begin
        hit  = 1'b0;
        rd_d = uefd_pkg::RST_VAL;
        unique case (paddr)
            uefd_pkg::OFF_CTRL: begin
                hit  = 1'b1;
                rd_d = {31'h0, host_q};
            end
            uefd_pkg::OFF_STATUS: begin
                hit  = 1'b1;
                rd_d = {16'h0, 5'h0, N_EP[2:0], 5'h0, armed_q};
            end
            uefd_pkg::OFF_IRQ: begin
                hit  = 1'b1;
                rd_d = irq_q;
            end
            uefd_pkg::OFF_ID: begin
                hit  = 1'b1;
                rd_d = uefd_pkg::ID_VALUE;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        for (int n = 0; n < N_EP; n++) begin
            if (ep_hit(paddr, n, uefd_pkg::SUB_TX_CFG)) begin
                hit  = 1'b1;
                rd_d = {16'h0, 1'b0, tx_cfg_q[n].max_pkt, 1'b0, tx_cfg_q[n].auto_op,
                        tx_cfg_q[n].mode, tx_cfg_q[n].dma_en};
            end
            if (ep_hit(paddr, n, uefd_pkg::SUB_RX_CFG)) begin
                hit  = 1'b1;
                rd_d = {16'h0, 1'b0, rx_cfg_q[n].max_pkt, 1'b0, rx_cfg_q[n].auto_op,
                        rx_cfg_q[n].mode, rx_cfg_q[n].dma_en};
            end
            if (ep_hit(paddr, n, uefd_pkg::SUB_TX_FIFO)) begin
                hit  = 1'b1;
                rd_d = {3'h0, tx_fifo_q[n].size, 4'h0, tx_fifo_q[n].start};
            end
            if (ep_hit(paddr, n, uefd_pkg::SUB_RX_FIFO)) begin
                hit  = 1'b1;
                rd_d = {3'h0, rx_fifo_q[n].size, 4'h0, rx_fifo_q[n].start};
            end
            if (ep_hit(paddr, n, uefd_pkg::SUB_TX_CNT)) begin
                hit  = 1'b1;
                rd_d = {19'h0, tx_cnt_q[n]};
            end
            if (ep_hit(paddr, n, uefd_pkg::SUB_RX_CNT)) begin
                hit  = 1'b1;
                rd_d = {19'h0, rx_cnt_q[n]};
            end
            if (ep_hit(paddr, n, uefd_pkg::SUB_DMA_LEN)) begin
                hit  = 1'b1;
                rd_d = {rx_len_q[n], tx_len_q[n]};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= uefd_pkg::RST_VAL;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_d;
        end
    end

    // role select; endpoint numbering is the reported number in both roles
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            host_q <= 1'b0;
        end else if (wr_acc && paddr == uefd_pkg::OFF_CTRL) begin
            host_q <= pwdata[uefd_pkg::CTRL_HOST];
        end
    end

    // per endpoint configuration; each endpoint has both sides
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int n = 0; n < N_EP; n++) begin
                tx_cfg_q[n]  <= '0;
                rx_cfg_q[n]  <= '0;
                tx_fifo_q[n] <= '0;
                rx_fifo_q[n] <= '0;
            end
        end else if (wr_acc) begin
            for (int n = 0; n < N_EP; n++) begin
                if (ep_hit(paddr, n, uefd_pkg::SUB_TX_CFG)) begin
                    tx_cfg_q[n] <= {pwdata[uefd_pkg::CFG_DMA_EN], uefd_pkg::uefd_mode_t'(pwdata[uefd_pkg::CFG_MODE]),
                                    pwdata[uefd_pkg::CFG_AUTO],
                                    pwdata[uefd_pkg::CFG_PKT_LSB +: uefd_pkg::CFG_PKT_W]};
                end
                if (ep_hit(paddr, n, uefd_pkg::SUB_RX_CFG)) begin
                    rx_cfg_q[n] <= {pwdata[uefd_pkg::CFG_DMA_EN], uefd_pkg::uefd_mode_t'(pwdata[uefd_pkg::CFG_MODE]),
                                    pwdata[uefd_pkg::CFG_AUTO],
                                    pwdata[uefd_pkg::CFG_PKT_LSB +: uefd_pkg::CFG_PKT_W]};
                end
                // illegal windows are dropped; layout can be rewritten at any time
                if (ep_hit(paddr, n, uefd_pkg::SUB_TX_FIFO) && fifo_ok(pwdata)) begin
                    tx_fifo_q[n] <= {pwdata[11:0], pwdata[uefd_pkg::FIFO_SIZE_LSB +: CW]};
                end
                if (ep_hit(paddr, n, uefd_pkg::SUB_RX_FIFO) && fifo_ok(pwdata)) begin
                    rx_fifo_q[n] <= {pwdata[11:0], pwdata[uefd_pkg::FIFO_SIZE_LSB +: CW]};
                end
            end
        end
    end

    // transmit side: fill by dma, auto arming, drain by link
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            armed_q <= '0;
            for (int n = 0; n < N_EP; n++) begin
                tx_cnt_q[n] <= '0;
                tx_len_q[n] <= '0;
            end
        end else begin
            for (int n = 0; n < N_EP; n++) begin
                tx_cnt_q[n] <= tx_cnt_q[n] + CW'(dma_tx_write[n] && tx_cnt_q[n] < tx_fifo_q[n].size)
                               - ((link_tx_taken[n] && armed_q[n]) ? CW'(tx_cfg_q[n].max_pkt) : CW'(0));
                if (link_tx_taken[n]) begin
                    armed_q[n] <= 1'b0;
                end else if (tx_cfg_q[n].auto_op && tx_cfg_q[n].max_pkt != 11'h0 &&
                             tx_cnt_q[n] >= CW'(tx_cfg_q[n].max_pkt)) begin
                    armed_q[n] <= 1'b1;
                end
                if (wr_acc && ep_hit(paddr, n, uefd_pkg::SUB_DMA_LEN)) begin
                    tx_len_q[n] <= pwdata[15:0];
                end else if (dma_tx_write[n] && tx_len_q[n] != 16'h0) begin
                    tx_len_q[n] <= tx_len_q[n] - 16'h1;
                end
            end
        end
    end

    // receive side: fill by link packets, drain by dma, auto release
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int n = 0; n < N_EP; n++) begin
                rx_cnt_q[n] <= '0;
                rx_pkt_q[n] <= '0;
                rx_len_q[n] <= '0;
            end
        end else begin
            for (int n = 0; n < N_EP; n++) begin
                if (link_rx_pkt[n].valid && rx_pkt_q[n] == '0) begin
                    rx_pkt_q[n] <= CW'(link_rx_pkt[n].bytes);
                    rx_cnt_q[n] <= CW'(link_rx_pkt[n].bytes);
                end else if (dma_rx_read[n] && rx_cnt_q[n] != '0) begin
                    rx_cnt_q[n] <= rx_cnt_q[n] - CW'(1);
                    if (rx_cnt_q[n] == CW'(1) && rx_cfg_q[n].auto_op) begin
                        rx_pkt_q[n] <= '0;
                    end
                end else if (wr_acc && ep_hit(paddr, n, uefd_pkg::SUB_RX_CNT) && rx_cnt_q[n] == '0) begin
                    rx_pkt_q[n] <= '0;
                end
                if (wr_acc && ep_hit(paddr, n, uefd_pkg::SUB_DMA_LEN)) begin
                    rx_len_q[n] <= pwdata[31:16];
                end else if (dma_rx_read[n] && rx_len_q[n] != 16'h0) begin
                    rx_len_q[n] <= rx_len_q[n] - 16'h1;
                end
            end
        end
    end

    // request lines only for endpoints 1..3; direction does not depend on the role
    always_comb begin
        for (int n = 0; n < N_EP; n++) begin
            dma_tx_req[n] = tx_cfg_q[n].dma_en && tx_len_q[n] != 16'h0 &&
                            tx_cnt_q[n] < tx_fifo_q[n].size;
            dma_rx_req[n] = rx_cfg_q[n].dma_en && rx_len_q[n] != 16'h0 &&
                            rx_cnt_q[n] != '0;
        end
    end
    assign link_tx_armed = armed_q;

    // interrupt sources: bit n tx (packet taken, or in block mode dma done or link error), 8+n rx, 16+n bus done; no dma-source flag
    always_comb begin
        irq_set = '0;
        for (int n = 0; n < N_EP; n++) begin
            if (tx_cfg_q[n].mode == uefd_pkg::UEFD_MODE_PER_PACKET) begin
                irq_set[n] = link_tx_taken[n] && armed_q[n];
            end else begin
                irq_set[n] = (dma_tx_write[n] && tx_len_q[n] == 16'h1) || link_err[n];
            end
            if (rx_cfg_q[n].mode == uefd_pkg::UEFD_MODE_PER_PACKET) begin
                irq_set[8+n] = dma_rx_read[n] && rx_len_q[n] == 16'h1;
            end else begin
                irq_set[8+n] = (dma_rx_read[n] && rx_len_q[n] == 16'h1) ||
                               (link_rx_pkt[n].valid && rx_pkt_q[n] == '0 &&
                                link_rx_pkt[n].bytes < rx_cfg_q[n].max_pkt) || link_err[n];
            end
            irq_set[16+n] = link_tx_done[n];
        end
    end

    assign irq_clr = (wr_acc && paddr == uefd_pkg::OFF_IRQ) ? pwdata : 32'h0;

    // sticky status, write one to clear, set wins; every source always enabled
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_q <= '0;
        end else begin
            irq_q <= (irq_q & ~irq_clr) | irq_set;
        end
    end
endmodule : uefd_top
`default_nettype wire

// ==== test/uefd_top_sva.sv ====
// concurrent checks on the ports of the endpoint fifo and dma request block
`timescale 1ns/1ps
`default_nettype none
module uefd_top_sva #(
    parameter int unsigned N_EP = uefd_pkg::NUM_EP
) (
    // clock and reset
    input wire logic                sys_clk,
    input wire logic                rst,
    // apb
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // link, dma and interrupt
    input wire logic [N_EP-1:0]     link_tx_taken,
    input wire logic [N_EP-1:0]     link_tx_done,
    input wire logic [N_EP-1:0]     link_err,
    input wire uefd_pkg::uefd_pkt_t link_rx_pkt [N_EP],
    input wire logic [N_EP-1:0]     link_tx_armed,
    input wire logic [N_EP-1:0]     dma_tx_write,
    input wire logic [N_EP-1:0]     dma_rx_read,
    input wire logic [N_EP-1:0]     dma_rx_req,
    input wire logic [N_EP-1:0]     dma_tx_req,
    input wire logic                irq
);
    logic            apb_wr;
    logic            calm;
    logic [N_EP-1:0] rx_v;
    logic [N_EP-1:0] quiet;
    logic [N_EP-1:0] tc;
    logic [N_EP-1:0] rc;
    assign apb_wr = psel & penable & pwrite;
    assign quiet  = ~(dma_tx_write | link_tx_taken | link_tx_done | link_err) & {N_EP{~apb_wr}};
    assign calm   = (&quiet) & ~|rx_v & ~|dma_rx_read;
    assign tc     = link_tx_taken | link_tx_done | link_err | {N_EP{apb_wr}};
    assign rc     = rx_v | {N_EP{apb_wr}};
    for (genvar g = 0; g < N_EP; g++) begin : g_rx
        assign rx_v[g] = link_rx_pkt[g].valid;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_pready; psel && penable |-> pready; endproperty
    a_pready: assert property (p_pready) else $error("access phase without ready");
    property p_unmapped; psel && penable && paddr >= 12'h0a0 |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on missing endpoint");
    property p_ep_count; psel && !penable && !pwrite && paddr == uefd_pkg::OFF_STATUS ##1 penable
        |-> prdata[10:8] == 3'(N_EP); endproperty
    a_ep_count: assert property (p_ep_count) else $error("wrong endpoint count");
    property p_rx_req_cause; (dma_rx_req & ~$past(dma_rx_req) & ~$past(rc) & ~$past(rc, 2)) == '0; endproperty
    a_rx_req_cause: assert property (p_rx_req_cause) else $error("rx request without data");
    property p_tx_req_cause; (dma_tx_req & ~$past(dma_tx_req) & ~$past(tc) & ~$past(tc, 2)) == '0; endproperty
    a_tx_req_cause: assert property (p_tx_req_cause) else $error("tx request without space");
    property p_armed_cause; (link_tx_armed & ~$past(link_tx_armed) & $past(quiet) & $past(quiet, 2)) == '0;
    endproperty
    a_armed_cause: assert property (p_armed_cause) else $error("armed without new data");
    property p_irq_sticky; irq && !apb_wr |=> irq; endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped by itself");
    property p_irq_cause; calm ##1 (calm && !irq) |=> !irq; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without event");
    c_armed: cover property (|link_tx_armed);
    c_irq: cover property ($rose(irq));
    c_rx: cover property (|dma_rx_req);
endmodule // uefd_top_sva
bind uefd_top uefd_top_sva #(.N_EP(N_EP)) i_sva (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_tx_taken(link_tx_taken), .link_tx_done(link_tx_done), .link_err(link_err), .link_rx_pkt(link_rx_pkt),
    .link_tx_armed(link_tx_armed), .dma_tx_write(dma_tx_write), .dma_rx_read(dma_rx_read),
    .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req), .irq(irq));
`default_nettype wire

// ==== test/uefd_far_model.sv ====
// far-side model: dma controller byte strobes and usb link events
`timescale 1ns/1ps
`default_nettype none
module uefd_far_model #(
    parameter int unsigned N = uefd_pkg::NUM_EP
) (
    // clock and pacing
    input  wire logic          sys_clk,
    input  wire logic          slow,
    // dma channels
    input  wire logic [N-1:0]  dma_tx_req,
    input  wire logic [N-1:0]  dma_rx_req,
    output logic      [N-1:0]  dma_tx_write,
    output logic      [N-1:0]  dma_rx_read,
    // usb link
    output logic      [N-1:0]  link_tx_taken,
    output logic      [N-1:0]  link_tx_done,
    output logic      [N-1:0]  link_err,
    output var uefd_pkg::uefd_pkt_t link_rx_pkt [N]
);
    logic ph_q;
    initial begin
        ph_q = 1'b0;
        dma_tx_write = '0;
        dma_rx_read = '0;
        link_tx_taken = '0;
        link_tx_done = '0;
        link_err = '0;
        for (int i = 0; i < N; i++) link_rx_pkt[i] = '{valid: 1'b0, bytes: 11'h000};
    end
    // bursts of single bytes; a gap after each lets the request settle first
    always @(posedge sys_clk) begin
        ph_q <= ~ph_q;
        dma_tx_write <= dma_tx_req & ~dma_tx_write & {N{~slow | ph_q}};
        dma_rx_read <= dma_rx_req & ~dma_rx_read & {N{~slow | ph_q}};
    end
    task automatic pulse(input int k, input int e);
        @(posedge sys_clk);
        link_tx_taken[e] <= (k == 0);
        link_tx_done[e] <= (k == 1);
        link_err[e] <= (k == 2);
        @(posedge sys_clk);
        link_tx_taken[e] <= 1'b0;
        link_tx_done[e] <= 1'b0;
        link_err[e] <= 1'b0;
    endtask
    task automatic packet(input int e, input logic [10:0] n);
        @(posedge sys_clk);
        link_rx_pkt[e] <= '{valid: 1'b1, bytes: n};
        @(posedge sys_clk);
        // idle length shows the inverse so a stale count never looks valid
        link_rx_pkt[e] <= '{valid: 1'b0, bytes: ~n};
    endtask
endmodule // uefd_far_model
`default_nettype wire

// ==== test/tb_usb_endpoint_fifo_dma.sv ====
// self-checking bench for the usb endpoint fifo and dma request block
`timescale 1ns/1ps
`default_nettype none
module tb_usb_endpoint_fifo_dma;
    localparam int unsigned N = uefd_pkg::NUM_EP;
    logic                sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, err, slow;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic [N-1:0]        taken, done, lerr, armed, txw, rxr, rxq, txq;
    uefd_pkg::uefd_pkt_t pkt [N];
    int                  fail_count, comparisons;
    uefd_top #(.N_EP(N)) i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_tx_taken(taken), .link_tx_done(done), .link_err(lerr), .link_rx_pkt(pkt), .link_tx_armed(armed),
        .dma_tx_write(txw), .dma_rx_read(rxr), .dma_rx_req(rxq), .dma_tx_req(txq), .irq(irq));
    uefd_far_model #(.N(N)) i_far (.sys_clk(sys_clk), .slow(slow), .dma_tx_req(txq), .dma_rx_req(rxq),
        .dma_tx_write(txw), .dma_rx_read(rxr), .link_tx_taken(taken), .link_tx_done(done), .link_err(lerr),
        .link_rx_pkt(pkt));
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;
    task automatic print_verdict;
        if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
        comparisons++;
        if (y !== x) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", s, x, y);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) chk("pready", 1, pready);
        if (pready !== 1'b1) print_verdict();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input string s);
        apb(1'b0, a, 32'h0);
        chk(s, x, rd & m);
    endtask
    function automatic logic [11:0] ea(input int e, input logic [2:0] s);
        return uefd_pkg::OFF_EP_BASE + 12'(e) * uefd_pkg::OFF_EP_STRIDE + {7'h00, s, 2'b00};
    endfunction
    // k 0: armed high, 1: rx request low, 2: tx request low
    task automatic await(input int k, input int e);
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge sys_clk);
            if ((k == 0 && armed[e] === 1'b1) || (k == 1 && rxq[e] === 1'b0) || (k == 2 && txq[e] === 1'b0)) break;
        end
        if (n == 400) chk("wait", 1, 0);
        if (n == 400) print_verdict();
    endtask
    task automatic t_regs;
        rdc(uefd_pkg::OFF_STATUS, 32'h700, 32'h300, "ep count");
        apb(1'b0, 12'h0a0, 32'h0);
        chk("unmapped", 1, err);
        apb(1'b1, uefd_pkg::OFF_CTRL, 32'h1);
        rdc(uefd_pkg::OFF_CTRL, 32'h1, 32'h1, "host role");
        apb(1'b1, uefd_pkg::OFF_CTRL, 32'h0);
        apb(1'b1, ea(2, uefd_pkg::SUB_TX_FIFO), 32'h0040_0fc0);
        rdc(ea(2, uefd_pkg::SUB_TX_FIFO), '1, 32'h0040_0fc0, "fifo at top");
        apb(1'b1, ea(2, uefd_pkg::SUB_TX_FIFO), 32'h0041_0fc0);
        rdc(ea(2, uefd_pkg::SUB_TX_FIFO), '1, 32'h0040_0fc0, "fifo past end");
        apb(1'b1, ea(2, uefd_pkg::SUB_TX_FIFO), 32'h0040_0020);
        rdc(ea(2, uefd_pkg::SUB_TX_FIFO), '1, 32'h0040_0fc0, "fifo in ep0 area");
    endtask
    task automatic t_tx_block;
        apb(1'b1, ea(0, uefd_pkg::SUB_TX_FIFO), 32'h0040_0040);
        apb(1'b1, ea(0, uefd_pkg::SUB_DMA_LEN), 32'h8);
        apb(1'b1, ea(0, uefd_pkg::SUB_TX_CFG), 32'h87);
        await(0, 0);
        rdc(ea(0, uefd_pkg::SUB_TX_CNT), '1, 32'h8, "tx count");
        rdc(uefd_pkg::OFF_IRQ, 32'h0001_0001, 32'h1, "tx dma done");
        apb(1'b1, uefd_pkg::OFF_IRQ, 32'h1);
        i_far.pulse(0, 0);
        i_far.pulse(1, 0);
        rdc(uefd_pkg::OFF_IRQ, 32'h0001_0001, 32'h0001_0000, "bus done only");
        chk("armed after send", 0, armed[0]);
    endtask
    task automatic t_tx_pkt;
        slow <= 1'b1;
        apb(1'b1, ea(1, uefd_pkg::SUB_TX_FIFO), 32'h0010_0080);
        apb(1'b1, ea(1, uefd_pkg::SUB_DMA_LEN), 32'h10);
        apb(1'b1, ea(1, uefd_pkg::SUB_TX_CFG), 32'h85);
        await(2, 1);
        chk("armed", 1, armed[1]);
        apb(1'b1, uefd_pkg::OFF_IRQ, 32'h2);
        i_far.pulse(0, 1);
        rdc(uefd_pkg::OFF_IRQ, 32'h2, 32'h2, "space event");
        slow <= 1'b0;
    endtask
    task automatic t_err;
        apb(1'b1, ea(2, uefd_pkg::SUB_DMA_LEN), 32'h8);
        apb(1'b1, ea(2, uefd_pkg::SUB_TX_CFG), 32'h86);
        repeat (2) @(posedge sys_clk);
        chk("tx req disabled", 0, txq[2]);
        apb(1'b1, uefd_pkg::OFF_IRQ, '1);
        chk("irq cleared", 0, irq);
        i_far.pulse(2, 2);
        @(posedge sys_clk);
        chk("irq on error", 1, irq);
        apb(1'b1, ea(2, uefd_pkg::SUB_TX_CFG), 32'h87);
        repeat (2) @(posedge sys_clk);
        chk("tx req enabled", 1, txq[2]);
    endtask
    task automatic t_rx_pkt;
        apb(1'b1, ea(0, uefd_pkg::SUB_RX_FIFO), 32'h0040_0200);
        apb(1'b1, ea(0, uefd_pkg::SUB_DMA_LEN), 32'h0010_0000);
        apb(1'b1, ea(0, uefd_pkg::SUB_RX_CFG), 32'h85);
        i_far.packet(0, 11'd8);
        await(1, 0);
        rdc(uefd_pkg::OFF_IRQ, 32'h100, 32'h0, "rx per packet");
        i_far.packet(0, 11'd8);
        await(1, 0);
        rdc(uefd_pkg::OFF_IRQ, 32'h100, 32'h100, "rx dma done");
    endtask
    task automatic t_rx_blk;
        apb(1'b1, ea(1, uefd_pkg::SUB_RX_FIFO), 32'h0040_0240);
        apb(1'b1, ea(1, uefd_pkg::SUB_DMA_LEN), 32'h0040_0000);
        apb(1'b1, ea(1, uefd_pkg::SUB_RX_CFG), 32'h83);
        apb(1'b1, uefd_pkg::OFF_IRQ, '1);
        i_far.packet(1, 11'd3);
        rdc(uefd_pkg::OFF_IRQ, 32'h200, 32'h200, "short packet");
        await(1, 1);
        i_far.packet(1, 11'd8);
        repeat (2) @(posedge sys_clk);
        chk("held packet", 0, rxq[1]);
        apb(1'b1, ea(1, uefd_pkg::SUB_RX_CNT), 32'h0);
        i_far.packet(1, 11'd8);
        repeat (2) @(posedge sys_clk);
        chk("released", 1, rxq[1]);
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        slow = 1'b0;
        fail_count = 0;
        comparisons = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_tx_block();
        t_tx_pkt();
        t_err();
        t_rx_pkt();
        t_rx_blk();
        print_verdict();
    end
endmodule // tb_usb_endpoint_fifo_dma
`default_nettype wire
